// File: hw/asp_uart.sv
// Behaviour
// - Start bit then data, LSB first
// - Optional parity, then one or two stops
// - Transmit only on tx line, LSB first
// - Receive line is input only, decoded
// - One channel, two pins, no handshake
// - No hardware flow control at all
// - Reset to 115200, 8N1
//
// Our own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.svh"
module asp_uart
  import asp_pkg::*;
#(
  parameter int DW = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic uart_tx,
  input wire logic uart_rx
);
  logic [31:0] ctrl;
  logic [15:0] div;
  logic ack;
  logic perr;
  logic ferr;
  logic ovr;
  // Transmit path
  logic txb_valid;
  logic txb_ready;
  logic [DW-1:0] txb_data;
  logic tx_wr;
  asp_state_t tx_st;
  logic [15:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [DW-1:0] tx_sh;
  logic tx_par;
  logic tx_stop_n;
  // Receive path
  logic rxb_in_valid;
  logic rxb_in_ready;
  logic [DW-1:0] rx_word;
  logic rxb_valid;
  logic rxb_pop;
  logic [DW-1:0] rxb_data;
  asp_state_t rx_st;
  logic [15:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [DW-1:0] rx_sh;
  logic rx_par;
  logic rx_s1;
  logic rx_s2;
  logic rx_prev;
  logic sts_clr;

  function automatic logic sel(input logic [3:0] a, input logic [3:0] off);
    sel = (a[3:2] == off[3:2]);
  endfunction : sel

  // Single-cycle answer: ack rises the cycle after the request
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign tx_wr = avs_write && ack && sel(avs_address, `ASP_OFF_DATA) && avs_byteenable[0];
  assign rxb_pop = avs_read && ack && sel(avs_address, `ASP_OFF_DATA);
  assign sts_clr = avs_write && ack && sel(avs_address, `ASP_OFF_STATUS);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl <= `ASP_CTRL_RST;
      div <= 16'(`ASP_DIV_RST);
    end else if (avs_write && ack) begin
      if (sel(avs_address, `ASP_OFF_CTRL) && avs_byteenable[0]) begin
        ctrl <= {29'h0, avs_writedata[2:0]};
      end
      if (sel(avs_address, `ASP_OFF_DIV)) begin
        if (avs_byteenable[0]) div[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1]) div[15:8] <= avs_writedata[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0;
    end else if ((avs_read || avs_write) && !ack) begin
      avs_readdata <= 32'h0;
      if (sel(avs_address, `ASP_OFF_DATA)) begin
        avs_readdata[DW-1:0] <= rxb_data;
      end else if (sel(avs_address, `ASP_OFF_STATUS)) begin
        avs_readdata[`ASP_ST_RXV] <= rxb_valid;
        avs_readdata[`ASP_ST_TXR] <= txb_ready;
        avs_readdata[`ASP_ST_PERR] <= perr;
        avs_readdata[`ASP_ST_FERR] <= ferr;
        avs_readdata[`ASP_ST_OVR] <= ovr;
        avs_readdata[`ASP_ST_TXBUSY] <= (tx_st != ASP_IDLE);
      end else if (sel(avs_address, `ASP_OFF_CTRL)) begin
        avs_readdata <= ctrl;
      end else begin
        avs_readdata[15:0] <= div;
      end
    end
  end

  // Software paces the link in-band; a full buffer drops writes
  asp_buf2 #(.W(DW)) u_txbuf (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(tx_wr),
    .in_ready(txb_ready),
    .in_data(avs_writedata[DW-1:0]),
    .out_valid(txb_valid),
    .out_ready(tx_st == ASP_IDLE),
    .out_data(txb_data)
  );

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_st <= ASP_IDLE;
      tx_cnt <= 16'h0;
      tx_bit <= 4'h0;
      tx_sh <= '0;
      tx_par <= 1'b0;
      tx_stop_n <= 1'b0;
      uart_tx <= 1'b1;
    end else if (tx_st != ASP_IDLE && tx_cnt != 16'h0) begin
      tx_cnt <= tx_cnt - 16'h1;
    end else begin
      tx_cnt <= div - 16'h1;
      unique case (tx_st)
        ASP_IDLE: begin
          uart_tx <= 1'b1;
          if (txb_valid) begin
            tx_sh <= txb_data;
            tx_par <= ctrl[`ASP_CTRL_PAR_ODD];
            uart_tx <= 1'b0;
            tx_st <= ASP_START;
          end
        end
        ASP_START, ASP_DATA: begin
          uart_tx <= tx_sh[0];
          tx_par <= tx_par ^ tx_sh[0];
          tx_sh <= tx_sh >> 1;
          tx_bit <= (tx_st == ASP_START) ? 4'h1 : tx_bit + 4'h1;
          tx_st <= ASP_DATA;
          if (tx_st == ASP_DATA && tx_bit == 4'(DW)) begin
            if (ctrl[`ASP_CTRL_PAR_EN]) begin
              uart_tx <= tx_par;
              tx_st <= ASP_PAR;
            end else begin
              uart_tx <= 1'b1;
              tx_stop_n <= ctrl[`ASP_CTRL_STOP2];
              tx_st <= ASP_STOP;
            end
          end
        end
        ASP_PAR: begin
          uart_tx <= 1'b1;
          tx_stop_n <= ctrl[`ASP_CTRL_STOP2];
          tx_st <= ASP_STOP;
        end
        ASP_STOP: begin
          tx_stop_n <= 1'b0;
          if (!tx_stop_n) begin
            tx_st <= ASP_IDLE;
            tx_cnt <= 16'h0;
          end
        end
      endcase
    end
  end

  // Receive line sampled, first flop feeds only the second
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1 <= uart_rx;
      rx_s2 <= rx_s1;
      rx_prev <= rx_s2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_st <= ASP_IDLE;
      rx_cnt <= 16'h0;
      rx_bit <= 4'h0;
      rx_sh <= '0;
      rx_par <= 1'b0;
      rxb_in_valid <= 1'b0;
      rx_word <= '0;
    end else begin
      rxb_in_valid <= 1'b0;
      if (rx_st != ASP_IDLE && rx_cnt != 16'h0) begin
        rx_cnt <= rx_cnt - 16'h1;
      end else begin
        unique case (rx_st)
          ASP_IDLE: begin
            if (rx_prev && !rx_s2) begin
              rx_cnt <= (div >> 1) - 16'h1;
              rx_st <= ASP_START;
            end
          end
          ASP_START: begin
            rx_cnt <= div - 16'h1;
            rx_bit <= 4'h0;
            rx_par <= ctrl[`ASP_CTRL_PAR_ODD];
            rx_st <= rx_s2 ? ASP_IDLE : ASP_DATA;
          end
          ASP_DATA: begin
            rx_cnt <= div - 16'h1;
            rx_sh <= {rx_s2, rx_sh[DW-1:1]};
            rx_par <= rx_par ^ rx_s2;
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit == 4'(DW - 1)) begin
              rx_st <= ctrl[`ASP_CTRL_PAR_EN] ? ASP_PAR : ASP_STOP;
            end
          end
          ASP_PAR: begin
            rx_cnt <= div - 16'h1;
            rx_par <= rx_par ^ rx_s2;
            rx_st <= ASP_STOP;
          end
          ASP_STOP: begin
            rx_word <= rx_sh;
            rxb_in_valid <= 1'b1;
            rx_st <= ASP_IDLE;
          end
        endcase
      end
    end
  end

  // Errors are sticky until software writes one to the bit; set wins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      perr <= 1'b0;
      ferr <= 1'b0;
      ovr <= 1'b0;
    end else begin
      perr <= (rx_st == ASP_STOP && rx_cnt == 16'h0 && ctrl[`ASP_CTRL_PAR_EN] && rx_par)
        || (perr && !(sts_clr && avs_writedata[`ASP_ST_PERR]));
      ferr <= (rx_st == ASP_STOP && rx_cnt == 16'h0 && !rx_s2)
        || (ferr && !(sts_clr && avs_writedata[`ASP_ST_FERR]));
      ovr <= (rxb_in_valid && !rxb_in_ready)
        || (ovr && !(sts_clr && avs_writedata[`ASP_ST_OVR]));
    end
  end

  asp_buf2 #(.W(DW)) u_rxbuf (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(rxb_in_valid),
    .in_ready(rxb_in_ready),
    .in_data(rx_word),
    .out_valid(rxb_valid),
    .out_ready(rxb_pop),
    .out_data(rxb_data)
  );

  a_bus_answer: assert property (@(posedge ref_clk) disable iff (srst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_tx_idle_high: assert property (@(posedge ref_clk) disable iff (srst)
    tx_st == ASP_IDLE && $past(tx_st) == ASP_IDLE |-> uart_tx)
    else $error("tx not idle high");
  a_tx_start_low: assert property (@(posedge ref_clk) disable iff (srst)
    tx_st == ASP_START |-> !uart_tx)
    else $error("start bit not low");
  a_tx_stop_high: assert property (@(posedge ref_clk) disable iff (srst)
    tx_st == ASP_STOP |-> uart_tx)
    else $error("stop bit not high");
  a_tx_lsb_first: assert property (@(posedge ref_clk) disable iff (srst)
    tx_st == ASP_START && tx_cnt == 16'h0 |=> tx_st == ASP_DATA && uart_tx == $past(tx_sh[0]))
    else $error("lsb not first");
  a_rx_start_det: assert property (@(posedge ref_clk) disable iff (srst)
    rx_st == ASP_IDLE && rx_prev && !rx_s2 |=> rx_st == ASP_START)
    else $error("start not detected");
  a_rx_push: assert property (@(posedge ref_clk) disable iff (srst)
    rx_st == ASP_STOP && rx_cnt == 16'h0 |=> rxb_in_valid && rx_st == ASP_IDLE)
    else $error("rx word not pushed");
  a_reset_cfg: assert property (@(posedge ref_clk)
    $past(srst) && !srst |-> div == 16'(`ASP_DIV_RST) && ctrl == `ASP_CTRL_RST)
    else $error("bad reset config");
  a_no_flow: assert property (@(posedge ref_clk) disable iff (srst)
    avs_write && avs_waitrequest && !txb_ready |=> !avs_waitrequest)
    else $error("full buffer stalls bus");
  c_tx_frame: cover property (@(posedge ref_clk) tx_st == ASP_STOP ##1 tx_st == ASP_IDLE);
  c_rx_word: cover property (@(posedge ref_clk) rxb_in_valid);
  c_parity: cover property (@(posedge ref_clk) tx_st == ASP_PAR);
  c_overrun: cover property (@(posedge ref_clk) $rose(ovr));
endmodule : asp_uart
`default_nettype wire

// File: pkg/asp_regs.svh
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
// Register byte offsets (word aligned)
`define ASP_OFF_DATA 4'h0
`define ASP_OFF_STATUS 4'h4
`define ASP_OFF_CTRL 4'h8
`define ASP_OFF_DIV 4'hC
// Control fields
`define ASP_CTRL_PAR_EN 0
`define ASP_CTRL_PAR_ODD 1
`define ASP_CTRL_STOP2 2
`define ASP_CTRL_RST 32'h0000_0000
// Status fields
`define ASP_ST_RXV 0
`define ASP_ST_TXR 1
`define ASP_ST_PERR 2
`define ASP_ST_FERR 3
`define ASP_ST_OVR 4
`define ASP_ST_TXBUSY 5
// Timing
`define ASP_CLK_HZ 25000000
`define ASP_BAUD 115200
`define ASP_DIV_RST ((`ASP_CLK_HZ + `ASP_BAUD / 2) / `ASP_BAUD)
`endif

// File: pkg/asp_pkg.sv
package asp_pkg;
  typedef enum logic [4:0] {
    ASP_IDLE = 5'b00001,
    ASP_START = 5'b00010,
    ASP_DATA = 5'b00100,
    ASP_PAR = 5'b01000,
    ASP_STOP = 5'b10000
  } asp_state_t;
endpackage : asp_pkg

// File: hw/asp_buf2.sv
`timescale 1ns/1ps
`default_nettype none
module asp_buf2 #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [0:1];
  logic wp;
  logic rp;
  logic [1:0] cnt;
  logic push;
  logic pop;
  assign in_ready = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wp <= 1'b0;
      rp <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) begin
        wp <= ~wp;
      end
      if (pop) begin
        rp <= ~rp;
      end
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : asp_buf2
`default_nettype wire

// File: tb/asp_peer.sv
`timescale 1ns/1ps
`default_nettype none
module asp_peer (
  input wire logic ref_clk,
  input wire logic tx_line,
  output logic rx_line,
  input wire logic [15:0] bit_cyc,
  input wire logic [3:0] nbits
);
  logic [10:0] got_q[$];
  logic [10:0] f;
  // Line held high between frames; no handshake pins exist
  initial rx_line = 1'b1;
  // Start edge, then one sample near each bit middle, LSB first
  initial forever begin
    @(negedge tx_line);
    repeat (bit_cyc / 2) @(posedge ref_clk);
    f = '1;
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_cyc) @(posedge ref_clk);
      f[i] = tx_line;
    end
    got_q.push_back(f);
  end
  task automatic send(input logic [10:0] fr, input logic [3:0] n);
    rx_line <= 1'b0;
    repeat (bit_cyc) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rx_line <= fr[i];
      repeat (bit_cyc) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
    @(posedge ref_clk);
  endtask : send
endmodule : asp_peer
`default_nettype wire

// File: tb/async_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd_v;
  logic avs_waitrequest;
  logic uart_tx;
  logic uart_rx;
  logic [15:0] bit_cyc = 16'hD9;
  logic [3:0] nbits = 4'h9;
  logic [10:0] fr;
  logic [2:0] c;
  int n_errors = 0;
  int samples_checked = 0;
  int k;

  always #20 ref_clk = ~ref_clk;

  asp_uart i_dut (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .uart_tx(uart_tx), .uart_rx(uart_rx));
  asp_peer i_peer (.ref_clk(ref_clk), .tx_line(uart_tx), .rx_line(uart_rx),
    .bit_cyc(bit_cyc), .nbits(nbits));

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic waitq(input int m);
    for (int n = 0; n < 3000 && i_peer.got_q.size() < m; n++) @(posedge ref_clk);
  endtask : waitq

  function automatic logic [10:0] mkf(input logic [7:0] d, input logic [2:0] m);
    mkf = {3'h7, d};
    if (m[0]) mkf[8] = ^d ^ m[1];
  endfunction : mkf

  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk("tx idle", 32'h1, 32'(uart_tx));
    bus(1'b0, 4'h8, 32'h0);
    chk("ctrl reset", 32'h0, rd_v);
    bus(1'b0, 4'hC, 32'h0);
    chk("div reset", 32'hD9, rd_v);
    bus(1'b0, 4'h4, 32'h0);
    chk("status reset", 32'h2, rd_v & 32'h3F);
    bus(1'b1, 4'h0, 32'hA5);
    waitq(1);
    chk("tx 8N1", 32'(mkf(8'hA5, 3'h0)), 32'(i_peer.got_q.pop_front()));
    i_peer.send(mkf(8'h3C, 3'h0), 4'h9);
    bus(1'b0, 4'h0, 32'h0);
    chk("rx 8N1", 32'h3C, rd_v & 32'hFF);
    $display("default test done");
    bus(1'b1, 4'hC, 32'h10);
    bit_cyc <= 16'h10;
    for (int m = 0; m < 4; m++) begin
      c = {m[1], m[0], 1'b1};
      bus(1'b1, 4'h8, 32'(c));
      nbits <= 4'h9 + 4'(c[0]) + 4'(c[2]);
      bus(1'b1, 4'h0, 32'(8'h96 ^ m[7:0]));
      waitq(1);
      chk("tx frame", 32'(mkf(8'h96 ^ m[7:0], c)), 32'(i_peer.got_q.pop_front()));
      i_peer.send(mkf(8'h69, c), nbits);
      bus(1'b0, 4'h0, 32'h0);
      chk("rx frame", 32'h69, rd_v & 32'hFF);
    end
    $display("mode test done");
    fr = mkf(8'h5A, c);
    fr[8] = ~fr[8];
    i_peer.send(fr, nbits);
    bus(1'b0, 4'h4, 32'h0);
    chk("parity flag", 32'h4, rd_v & 32'h4);
    bus(1'b1, 4'h4, 32'h4);
    bus(1'b0, 4'h4, 32'h0);
    chk("parity clear", 32'h0, rd_v & 32'h4);
    bus(1'b0, 4'h0, 32'h0);
    bus(1'b1, 4'h8, 32'h0);
    nbits <= 4'h9;
    fr = mkf(8'h33, 3'h0);
    fr[8] = 1'b0;
    i_peer.send(fr, 4'h9);
    bus(1'b0, 4'h4, 32'h0);
    chk("frame flag", 32'h8, rd_v & 32'h8);
    bus(1'b0, 4'h0, 32'h0);
    $display("error test done");
    k = 0;
    for (int n = 0; n < 5; n++) begin
      bus(1'b0, 4'h4, 32'h0);
      if (rd_v[1] === 1'b1) begin
        bus(1'b1, 4'h0, 32'(8'h10 + k[7:0]));
        k++;
      end
    end
    bus(1'b1, 4'h0, 32'hEE);
    bus(1'b0, 4'h4, 32'h0);
    chk("tx busy full", 32'h20, rd_v & 32'h22);
    waitq(k + 1);
    chk("tx depth", 32'h1, 32'(k >= 2));
    chk("tx count", 32'(k), 32'(i_peer.got_q.size()));
    for (int n = 0; n < k; n++)
      chk("tx order", 32'(mkf(8'h10 + n[7:0], 3'h0)), 32'(i_peer.got_q.pop_front()));
    // Reader stalls while two words arrive
    i_peer.send(mkf(8'hC1, 3'h0), 4'h9);
    i_peer.send(mkf(8'h7E, 3'h0), 4'h9);
    bus(1'b0, 4'h0, 32'h0);
    chk("rx first", 32'hC1, rd_v & 32'hFF);
    bus(1'b0, 4'h0, 32'h0);
    chk("rx second", 32'h7E, rd_v & 32'hFF);
    bus(1'b0, 4'h4, 32'h0);
    chk("rx no overrun", 32'h0, rd_v & 32'h11);
    // Third unread word finds the buffer full
    for (int n = 0; n < 3; n++) i_peer.send(mkf(8'h40 + n[7:0], 3'h0), 4'h9);
    bus(1'b0, 4'h4, 32'h0);
    chk("overrun flag", 32'h11, rd_v & 32'h11);
    bus(1'b0, 4'h0, 32'h0);
    chk("overrun oldest", 32'h40, rd_v & 32'hFF);
    $display("buffer test done");
    summarize();
  end

  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
endmodule : async_serial_port_tb
`default_nettype wire
